// File: write_verify_and_health_report_test.sv
// Bench driving the task file over APB, with a flash back-end model.
// Assumes four chips; results come from the rules and package constants.
`timescale 1ns/10ps
module write_verify_and_health_report_test
	import wvhr_pkg::*;
;
	logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, fail = 0, e;
	logic [7:0] paddr = 0, sum;
	logic [31:0] pwdata = 0, prdata, q, mce = 0;
	logic pready, pslverr, intrq, prog_req, vfy_req, prog_done, vfy_done, vfy_ok, nv_out;
	logic nv_wr, lba_mode;
	logic [27:0] lba;
	logic [7:0] buf_addr;
	logic [15:0] buf_data;
	logic [15:0] w [256];
	logic [3:0] dly = 4'h4;
	logic [63:0] init_spare = {4{16'h0064}};
	logic [63:0] cur_spare = {16'h0050, 16'h0046, 16'h003c, 16'h0032};
	int fail_count = 0, n_checks = 0;
	localparam logic [7:0] RA [6] = '{OFS_FEATURE, OFS_SECCNT, OFS_LBA_LO, OFS_DEVHEAD,
		OFS_SPARE_THR, OFS_ERROR};
	localparam logic [7:0] RV [6] = '{8'h00, 8'h01, 8'h01, 8'ha0, 8'h0a, 8'h00};
	localparam logic [7:0] EI [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'hb8, 8'hc1, 8'hc2};
	localparam logic [15:0] EW [10] = '{16'h0010, 16'h03c4, 16'h3200, 16'h9032, 16'h0001,
		16'h0104, 16'h0000, 16'h0003, 16'h0004, 16'h5678};
	localparam logic [7:0] HF [5] = '{FEAT_AUTOSAVE, FEAT_AUTOSAVE, FEAT_AUTOSAVE, 8'hd3, 8'hdb};
	localparam logic [7:0] HS [5] = '{AUTOSAVE_OFF, AUTOSAVE_ON, 8'h05, 8'h00, 8'h00};
	localparam logic HA [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

	wvhr_top DUT (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .intrq, .media_prog_req(prog_req), .media_vfy_req(vfy_req),
		.media_lba(lba), .media_lba_mode(lba_mode), .media_buf_addr(buf_addr),
		.media_buf_data(buf_data), .media_prog_done(prog_done), .media_vfy_done(vfy_done),
		.media_vfy_ok(vfy_ok), .init_spare, .cur_spare,
		.commit_cnt(32'h12345678), .wl_thr(32'h00000100), .avg_erase(32'h00000020),
		.wl_blocks(32'h00000008), .max_chip_erase(mce), .nv_enable_in(1'b0),
		.nv_enable_out(nv_out), .nv_write(nv_wr));
	wvhr_media_model u_media (.clk_sys, .rst_b, .prog_req, .vfy_req, .fail, .dly, .prog_done,
		.vfy_done, .vfy_ok, .buf_addr);

	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic stop_test();
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Polls alternate status, which leaves the interrupt alone
	task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
		repeat (3) @(posedge clk_sys);
		do
			apb(1'b0, OFS_ALT_STAT, 32'h0);
		while ((q[7:0] & m) !== v);
	endtask

	task automatic hcmd(input logic [7:0] f, input logic [7:0] sc, input logic ab);
		apb(1'b1, OFS_FEATURE, {24'h0, f});
		apb(1'b1, OFS_SECCNT, {24'h0, sc});
		apb(1'b1, OFS_LBA_MID, {24'h0, KEY_LO});
		apb(1'b1, OFS_LBA_HI, {24'h0, KEY_HI});
		apb(1'b1, OFS_DEVHEAD, 32'he0);
		apb(1'b1, OFS_CMD_STAT, {24'h0, CMD_HEALTH});
		wait_st(8'h80, 8'h00);
		apb(1'b0, OFS_ERROR, 32'h0);
		chk(q[ER_ABRT], ab);
	endtask

	task automatic rd_sector();
		sum = 8'h00;
		for (int i = 0; i < 256; i++)
		begin
			apb(1'b0, OFS_DATA, 32'h0);
			w[i] = q[15:0];
			sum = sum + q[15:8] + q[7:0];
		end
		chk(sum, 8'h00);
	endtask

	task automatic wr_sector(input logic [27:0] a, input logic irq);
		wait_st(8'h88, 8'h08);
		chk(intrq, irq);
		for (int i = 0; i < 256; i++)
			apb(1'b1, OFS_DATA, 32'(i));
		chk(lba, a);
		chk(lba_mode, 1'b1);
		@(posedge clk_sys) sum = buf_addr;
		@(posedge clk_sys) chk(buf_data, {8'h00, sum});
	endtask

	task automatic wv_cmd(input logic [7:0] sc, input logic [7:0] lo);
		apb(1'b1, OFS_SECCNT, {24'h0, sc});
		apb(1'b1, OFS_LBA_LO, {24'h0, lo});
		apb(1'b1, OFS_LBA_MID, 32'h0);
		apb(1'b1, OFS_LBA_HI, 32'h0);
		apb(1'b1, OFS_DEVHEAD, 32'he0);
		apb(1'b1, OFS_CMD_STAT, {24'h0, CMD_WRITE_VERIFY});
	endtask

	initial
	begin
		#100000;
		fail_count++;
		stop_test();
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, RA[i], 32'h0);
			chk(q, {24'h0, RV[i]});
		end
		apb(1'b0, 8'h40, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0);
		wv_cmd(8'h02, 8'h10);
		wr_sector(28'h0000010, 1'b0);
		wr_sector(28'h0000011, 1'b1);
		wait_st(8'h88, 8'h00);
		chk(intrq, 1'b1);
		apb(1'b0, OFS_CMD_STAT, 32'h0);
		chk(q[ST_ERR], 1'b0);
		// Prompt back end and a failing verify on the first of three
		dly <= 4'h0;
		fail <= 1'b1;
		wv_cmd(8'h03, 8'h20);
		wr_sector(28'h0000020, 1'b0);
		wait_st(8'h88, 8'h00);
		fail <= 1'b0;
		apb(1'b0, OFS_ERROR, 32'h0);
		chk(q[ER_UNC], 1'b1);
		apb(1'b0, OFS_LBA_LO, 32'h0);
		chk(q, 32'h20);
		apb(1'b0, OFS_SECCNT, 32'h0);
		chk(q, 32'h03);
		hcmd(FEAT_ENABLE, 8'h00, 1'b0);
		chk(nv_out, 1'b1);
		for (int i = 0; i < 5; i++)
			hcmd(HF[i], HS[i], HA[i]);
		hcmd(FEAT_READ_DATA, 8'h00, 1'b0);
		rd_sector();
		for (int i = 0; i < 10; i++)
			chk(w[EI[i]], EW[i]);
		chk(w[195], 16'h1234);
		chk(w[198], 16'h0000);
		hcmd(FEAT_READ_THR, 8'h00, 1'b0);
		rd_sector();
		chk(w[0], HEALTH_VERSION);
		chk(w[2], 16'h0a00);
		for (int t = 0; t < 2; t++)
		begin
			apb(1'b1, OFS_SPARE_THR, 32'h32 + 32'(t));
			hcmd(FEAT_STATUS, 8'h00, 1'b0);
			apb(1'b0, OFS_LBA_HI, 32'h0);
			chk(q, t ? 32'h2c : 32'hc2);
		end
		cur_spare[15:0] <= 16'h0000;
		mce <= 32'h100;
		hcmd(FEAT_READ_DATA, 8'h00, 1'b0);
		rd_sector();
		chk(w[2], 16'h0000);
		chk(w[198][7:0], 8'h01);
		chk(w[198][15:8], 8'h01);
		hcmd(FEAT_DISABLE, 8'h00, 1'b0);
		chk(nv_out, 1'b0);
		hcmd(FEAT_READ_DATA, 8'h00, 1'b1);
		stop_test();
	end
endmodule

// File: wvhr_checker.sv
// Port-level checks on the verified-write and health-report block.
// Assumes binding to every wvhr_top instance.
`timescale 1ns/10ps
module wvhr_checker
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic media_prog_req,
	input wire logic media_vfy_req,
	input wire logic [27:0] media_lba,
	input wire logic media_prog_done,
	input wire logic media_vfy_done,
	input wire logic nv_write
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	property p_rdy;
		psel && penable |-> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("access phase without pready");
	property p_unmap;
		psel && penable && paddr > 8'h28 |-> pslverr;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
	property p_vfy_start;
		$rose(media_vfy_req) |-> $past(media_prog_done);
	endproperty
	a_vfy_start: assert property (p_vfy_start) else $error("verify not after program");
	property p_excl;
		!(media_prog_req && media_vfy_req);
	endproperty
	a_excl: assert property (p_excl) else $error("program and verify overlap");
	property p_prog_hold;
		media_prog_req && !media_prog_done |=> media_prog_req;
	endproperty
	a_prog_hold: assert property (p_prog_hold) else $error("program request dropped");
	property p_vfy_hold;
		media_vfy_req && !media_vfy_done |=> media_vfy_req;
	endproperty
	a_vfy_hold: assert property (p_vfy_hold) else $error("verify request dropped");
	property p_prog_end;
		$fell(media_prog_req) |-> $past(media_prog_done);
	endproperty
	a_prog_end: assert property (p_prog_end) else $error("program ended early");
	property p_lba;
		(media_prog_req || media_vfy_req) && $past(media_prog_req || media_vfy_req)
			|-> $stable(media_lba);
	endproperty
	a_lba: assert property (p_lba) else $error("sector address moved mid sector");
	property p_nv;
		nv_write |=> !nv_write;
	endproperty
	a_nv: assert property (p_nv) else $error("store pulse too long");
endmodule

bind wvhr_top wvhr_checker u_chk (.clk_sys, .rst_b, .psel, .penable, .paddr, .pready,
	.pslverr, .media_prog_req, .media_vfy_req, .media_lba, .media_prog_done,
	.media_vfy_done, .nv_write);

// File: wvhr_media_model.sv
// Behavioural flash back end that programs and verifies one sector.
// Assumes level requests from the block; answers dly+1 cycles after a request.
`timescale 1ns/10ps
module wvhr_media_model
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic prog_req,
	input wire logic vfy_req,
	input wire logic fail,
	input wire logic [3:0] dly,
	output logic prog_done,
	output logic vfy_done,
	output logic vfy_ok,
	output logic [7:0] buf_addr
);
	logic [3:0] cnt;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{prog_done, vfy_done, vfy_ok, cnt, buf_addr} <= '0;
		end
		else
		begin
			prog_done <= 1'b0;
			vfy_done <= 1'b0;
			// Outside a done pulse the result toggles, never a stale pass
			vfy_ok <= ~vfy_ok;
			buf_addr <= buf_addr + 8'h01;
			if ((prog_req && !prog_done) || (vfy_req && !vfy_done))
			begin
				cnt <= cnt + 4'h1;
				if (cnt >= dly)
				begin
					cnt <= 4'h0;
					prog_done <= prog_req;
					vfy_done <= vfy_req;
					vfy_ok <= !fail;
				end
			end
		end
	end
endmodule

// File: wvhr_pkg.sv
// Package for the verified-write and health-report command block.
// Assumes an APB master on the same clock and a flash manager that supplies counters.
package wvhr_pkg;
	// APB byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_FEATURE = 8'h04;
	localparam logic [7:0] OFS_SECCNT = 8'h08;
	localparam logic [7:0] OFS_LBA_LO = 8'h0c;
	localparam logic [7:0] OFS_LBA_MID = 8'h10;
	localparam logic [7:0] OFS_LBA_HI = 8'h14;
	localparam logic [7:0] OFS_DEVHEAD = 8'h18;
	localparam logic [7:0] OFS_CMD_STAT = 8'h1c;
	localparam logic [7:0] OFS_ERROR = 8'h20;
	localparam logic [7:0] OFS_SPARE_THR = 8'h24;
	localparam logic [7:0] OFS_ALT_STAT = 8'h28;
	// Command and feature codes
	localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3c;
	localparam logic [7:0] CMD_HEALTH = 8'hb0;
	localparam logic [7:0] FEAT_READ_DATA = 8'hd0;
	localparam logic [7:0] FEAT_READ_THR = 8'hd1;
	localparam logic [7:0] FEAT_AUTOSAVE = 8'hd2;
	localparam logic [7:0] FEAT_ENABLE = 8'hd8;
	localparam logic [7:0] FEAT_DISABLE = 8'hd9;
	localparam logic [7:0] FEAT_STATUS = 8'hda;
	localparam logic [7:0] AUTOSAVE_OFF = 8'h00;
	localparam logic [7:0] AUTOSAVE_ON = 8'hf1;
	localparam logic [7:0] KEY_HI = 8'hc2;
	localparam logic [7:0] KEY_LO = 8'h4f;
	localparam logic [7:0] KEY_HI_EXCEEDED = 8'h2c;
	localparam logic [7:0] KEY_LO_EXCEEDED = 8'hf4;
	localparam logic [2:0] DEVHEAD_FIXED_MASK = 3'h5;
	// Health sector layout
	localparam logic [15:0] HEALTH_VERSION = 16'h0010;
	localparam logic [15:0] VENDOR_VERSION = 16'h0004;
	localparam logic [15:0] CAPABILITY_WORD = 16'h0003;
	localparam logic [7:0] SPARE_ATTR_ID = 8'hc4;
	localparam logic [15:0] SPARE_ATTR_FLAGS = 16'h0003;
	localparam logic [7:0] ATTR_BASE_WORD = 8'h01;
	localparam logic [7:0] CAP_WORD_IDX = 8'hb8;
	localparam logic [7:0] VEND_VER_IDX = 8'hc1;
	localparam logic [7:0] COMMIT_IDX = 8'hc2;
	localparam logic [7:0] WL_THR_IDX = 8'hc4;
	localparam logic [7:0] FLAGS_IDX = 8'hc6;
	localparam logic [7:0] AVG_ERASE_IDX = 8'hc7;
	localparam logic [7:0] WL_BLOCKS_IDX = 8'hc9;
	localparam logic [7:0] LAST_WORD_IDX = 8'hff;
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] SPARE_THR_RESET = 8'h0a;
	// Status and error bits
	localparam int ST_BSY = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_UNC = 6;
	localparam int ER_ABRT = 2;
	localparam logic [8:0] FULL_COUNT = 9'h100;
endpackage

// File: wvhr_sector_word.sv
// Word-by-word image of the 512-byte health sector, low byte first in each word.
// Assumes the caller supplies a stable snapshot and the running checksum.
`timescale 1ns/10ps
module wvhr_sector_word
	import wvhr_pkg::*;
(
	input wire logic [7:0] word_idx,
	input wire logic thr_mode,
	input wire logic [7:0] spare_value,
	input wire logic [7:0] spare_worst,
	input wire logic [7:0] spare_thr,
	input wire logic [23:0] init_sum,
	input wire logic [23:0] cur_sum,
	input wire logic [31:0] commit_cnt,
	input wire logic [31:0] wl_thr,
	input wire logic [31:0] avg_erase,
	input wire logic [31:0] wl_blocks,
	input wire logic global_bbm,
	input wire logic global_wl,
	input wire logic [7:0] checksum,
	output logic [15:0] word
);
	// Spare record occupies bytes 2..13, words 1..6
	always_comb
	begin
		word = 16'h0000; // RULE_14
		case (word_idx)
			8'h00: word = HEALTH_VERSION; // RULE_13
			ATTR_BASE_WORD: word = {SPARE_ATTR_FLAGS[7:0], SPARE_ATTR_ID}; // RULE_23
			ATTR_BASE_WORD + 8'h01: word = {spare_value, SPARE_ATTR_FLAGS[15:8]}; // RULE_24
			ATTR_BASE_WORD + 8'h02: word = {init_sum[7:0], spare_worst};
			ATTR_BASE_WORD + 8'h03: word = init_sum[23:8]; // RULE_25
			ATTR_BASE_WORD + 8'h04: word = cur_sum[15:0];
			ATTR_BASE_WORD + 8'h05: word = {8'h00, cur_sum[23:16]}; // RULE_20
			CAP_WORD_IDX: word = CAPABILITY_WORD; // RULE_15
			VEND_VER_IDX: word = VENDOR_VERSION; // RULE_16
			COMMIT_IDX: word = commit_cnt[15:0]; // RULE_19
			COMMIT_IDX + 8'h01: word = commit_cnt[31:16];
			WL_THR_IDX: word = wl_thr[15:0]; // RULE_17
			WL_THR_IDX + 8'h01: word = wl_thr[31:16];
			FLAGS_IDX: word = {7'h00, global_wl, 7'h00, global_bbm};
			AVG_ERASE_IDX: word = avg_erase[15:0];
			AVG_ERASE_IDX + 8'h01: word = avg_erase[31:16];
			WL_BLOCKS_IDX: word = wl_blocks[15:0];
			WL_BLOCKS_IDX + 8'h01: word = wl_blocks[31:16];
			LAST_WORD_IDX: word = {checksum, 8'h00}; // RULE_18
			default: word = 16'h0000;
		endcase
		// Threshold sector keeps version, id, flags, threshold and checksum only
		if (thr_mode && word_idx == ATTR_BASE_WORD + 8'h01)
			word = {spare_thr, SPARE_ATTR_FLAGS[15:8]};
		else if (thr_mode && word_idx > ATTR_BASE_WORD + 8'h01 && word_idx != LAST_WORD_IDX)
			word = 16'h0000;
	end
endmodule

// File: wvhr_spare_eval.sv
// Spare-block attribute evaluation over all flash chips.
// Assumes per-chip spare counts arrive on the system clock, 16 bits each.
`timescale 1ns/10ps
module wvhr_spare_eval
	import wvhr_pkg::*;
#(
	parameter int NCHIP = 4
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [NCHIP*16-1:0] init_spare,
	input wire logic [NCHIP*16-1:0] cur_spare,
	output logic [7:0] spare_value,
	output logic [7:0] spare_worst,
	output logic [23:0] init_sum,
	output logic [23:0] cur_sum,
	output logic any_exhausted
);
	function automatic logic [7:0] pct(input logic [15:0] cur, input logic [15:0] init);
		logic [23:0] num;
		num = 24'(cur) * 24'(PCT_FULL);
		if (init == 16'h0000)
			pct = 8'h00;
		else
			pct = 8'(num / 24'(init));
	endfunction

	logic [7:0] next_min;
	logic [23:0] next_isum;
	logic [23:0] next_csum;
	logic next_exh;
	always_comb
	begin
		next_min = 8'hff;
		next_isum = 24'h000000;
		next_csum = 24'h000000;
		next_exh = 1'b0;
		for (int i = 0; i < NCHIP; i++)
		begin
			if (pct(cur_spare[i*16 +: 16], init_spare[i*16 +: 16]) < next_min)
				next_min = pct(cur_spare[i*16 +: 16], init_spare[i*16 +: 16]); // RULE_24
			next_isum = next_isum + 24'(init_spare[i*16 +: 16]); // RULE_25
			next_csum = next_csum + 24'(cur_spare[i*16 +: 16]);
			next_exh = next_exh | (cur_spare[i*16 +: 16] == 16'h0000);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			spare_value <= PCT_FULL;
			spare_worst <= PCT_FULL;
			init_sum <= 24'h000000;
			cur_sum <= 24'h000000;
			any_exhausted <= 1'b0;
		end
		else
		begin
			spare_value <= next_min;
			if (next_min < spare_worst)
				spare_worst <= next_min; // RULE_24
			init_sum <= next_isum;
			cur_sum <= next_csum;
			any_exhausted <= next_exh;
		end
	end
endmodule

// File: wvhr_top.sv
// Verified sector write and health-report command handling behind an APB task file.
// Assumes APB on clk_sys, and a flash back end that programs and verifies one sector.
// How it works
// [RULE_01] Command 3Ch writes each sector, then verifies it before the next.
// [RULE_02] Same handshake as plain sector write.
// [RULE_03] Host loads drive/head with bits 7,5 set; other bytes carry address.
// [RULE_04] Sector count 1..256, zero meaning 256.
// [RULE_05] BSY, then DRQ without interrupt; later DRQ and completion interrupt.
// [RULE_06] Error stops at failing sector, its address kept.
// [RULE_07] Feature selects health operation: D0h,D1h,D2h,D8h,D9h,DAh.
// [RULE_08] Other feature values abort with no further effect.
// [RULE_09] Host sends opcode B0h with key bytes C2h and 4Fh.
// [RULE_10] D8h enables, D9h disables health access; state kept nonvolatile.
// [RULE_11] D2h with count 00h or F1h completes and changes nothing.
// [RULE_12] Read data returns one 512-byte sector.
// [RULE_13] Bytes 0-1 hold structure version 0010h.
// [RULE_14] Bytes 2-361 hold thirty 12-byte entries, undefined ones zero.
// [RULE_15] Fixed capability fields, word 0003h at bytes 368-369, rest zero.
// [RULE_16] Bytes 386-387 hold vendor structure version 0004h.
// [RULE_17] Vendor counters at 388-405, bytes 406-510 zero.
// [RULE_18] Byte 511 makes the sum of all bytes zero modulo 256.
// [RULE_19] Multi-byte values are little endian.
// [RULE_20] Twelve attributes defined, each a 12-byte record; the code fills only the spare record (id c4h).
// [RULE_21] Byte 396 becomes 1 once any chip has exhausted its spares.
// [RULE_22] Byte 397 becomes 1 once the busiest chip reaches the erase threshold.
// [RULE_23] Spare record: id c4h, flags 0003h, byte 11 zero.
// [RULE_24] Spare value is the per-chip minimum percentage; byte 4 the worst.
// [RULE_25] Bytes 5-7 initial spare total, bytes 8-10 current total.
// [RULE_26] Return status flags spare value below threshold.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module wvhr_top
	import wvhr_pkg::*;
#(
	parameter int NCHIP = 4,
	parameter int BUF_WORDS = 256
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic intrq,
	output logic media_prog_req,
	output logic media_vfy_req,
	output logic [27:0] media_lba,
	output logic media_lba_mode,
	input wire logic [7:0] media_buf_addr,
	output logic [15:0] media_buf_data,
	input wire logic media_prog_done,
	input wire logic media_vfy_done,
	input wire logic media_vfy_ok,
	input wire logic [NCHIP*16-1:0] init_spare,
	input wire logic [NCHIP*16-1:0] cur_spare,
	input wire logic [31:0] commit_cnt,
	input wire logic [31:0] wl_thr,
	input wire logic [31:0] avg_erase,
	input wire logic [31:0] wl_blocks,
	input wire logic [31:0] max_chip_erase,
	input wire logic nv_enable_in,
	output logic nv_enable_out,
	output logic nv_write
);
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_ACCEPT = 6'b000010,
		S_WR_DRQ = 6'b000100,
		S_PROG = 6'b001000,
		S_VERIFY = 6'b010000,
		S_RD_DRQ = 6'b100000
	} wvhr_state_e;

	wvhr_state_e state;
	logic [7:0] feature;
	logic [7:0] seccnt;
	logic [7:0] lba_lo;
	logic [7:0] lba_mid;
	logic [7:0] lba_hi;
	logic [7:0] devhead;
	logic [7:0] error;
	logic [7:0] spare_thr;
	logic err_flag;
	logic health_en;
	logic nv_loaded;
	logic [8:0] remaining;
	logic [7:0] word_ptr;
	logic [7:0] cksum;
	logic thr_mode;
	logic is_write;
	logic [15:0] sector_buf [BUF_WORDS];
	logic [31:0] snap_commit;
	logic [31:0] snap_wl_thr;
	logic [31:0] snap_avg;
	logic [31:0] snap_blocks;
	logic snap_bbm;
	logic snap_wl;
	logic global_bbm;
	logic global_wl;
	logic [7:0] spare_value;
	logic [7:0] spare_worst;
	logic [23:0] init_sum;
	logic [23:0] cur_sum;
	logic any_exhausted;
	logic [15:0] sector_word;
	logic [7:0] status;
	logic setup;
	logic access;
	logic wr_cmd;
	logic rd_data;
	logic wr_data;
	logic rd_status;
	logic mapped;

	function automatic logic [27:0] addr_of(input logic [7:0] dh, input logic [7:0] hi,
		input logic [7:0] mid, input logic [7:0] lo);
		addr_of = {dh[3:0], hi, mid, lo}; // RULE_03
	endfunction

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign mapped = (paddr <= OFS_ALT_STAT) && (paddr[1:0] == 2'b00);
	assign wr_cmd = access && pwrite && paddr == OFS_CMD_STAT && state == S_IDLE;
	assign wr_data = access && pwrite && paddr == OFS_DATA && state == S_WR_DRQ;
	assign rd_data = access && !pwrite && paddr == OFS_DATA && state == S_RD_DRQ;
	assign rd_status = access && !pwrite && paddr == OFS_CMD_STAT;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign media_lba = addr_of(devhead, lba_hi, lba_mid, lba_lo);
	assign media_lba_mode = devhead[6];
	assign nv_enable_out = health_en;

	always_comb
	begin
		status = 8'h00;
		status[ST_BSY] = state == S_ACCEPT || state == S_PROG || state == S_VERIFY; // RULE_05
		status[ST_DRDY] = state == S_IDLE;
		status[ST_DRQ] = state == S_WR_DRQ || state == S_RD_DRQ;
		status[ST_ERR] = err_flag;
	end

	wvhr_spare_eval #(
		.NCHIP(NCHIP)
	) u_spare (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.init_spare(init_spare),
		.cur_spare(cur_spare),
		.spare_value(spare_value),
		.spare_worst(spare_worst),
		.init_sum(init_sum),
		.cur_sum(cur_sum),
		.any_exhausted(any_exhausted)
	);

	wvhr_sector_word u_word (
		.word_idx(word_ptr),
		.thr_mode(thr_mode),
		.spare_value(spare_value),
		.spare_worst(spare_worst),
		.spare_thr(spare_thr),
		.init_sum(init_sum),
		.cur_sum(cur_sum),
		.commit_cnt(snap_commit),
		.wl_thr(snap_wl_thr),
		.avg_erase(snap_avg),
		.wl_blocks(snap_blocks),
		.global_bbm(snap_bbm),
		.global_wl(snap_wl),
		.checksum(8'(8'h00 - cksum)),
		.word(sector_word)
	);

	// Read data is latched in the setup cycle; the pop happens at the access edge
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prdata <= '0;
		else if (setup && !pwrite)
		begin
			case (paddr)
				OFS_DATA: prdata <= state == S_RD_DRQ ? 32'(sector_word) : '0;
				OFS_FEATURE: prdata <= 32'(feature);
				OFS_SECCNT: prdata <= 32'(seccnt);
				OFS_LBA_LO: prdata <= 32'(lba_lo); // RULE_06
				OFS_LBA_MID: prdata <= 32'(lba_mid);
				OFS_LBA_HI: prdata <= 32'(lba_hi);
				OFS_DEVHEAD: prdata <= 32'(devhead);
				OFS_CMD_STAT: prdata <= 32'(status);
				OFS_ERROR: prdata <= 32'(error);
				OFS_SPARE_THR: prdata <= 32'(spare_thr);
				OFS_ALT_STAT: prdata <= 32'(status);
				default: prdata <= '0;
			endcase
		end
	end

	// Sticky progress flags fed by the flash manager
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			global_bbm <= 1'b0;
			global_wl <= 1'b0;
		end
		else
		begin
			if (any_exhausted)
				global_bbm <= 1'b1; // RULE_21
			if (max_chip_erase >= wl_thr)
				global_wl <= 1'b1; // RULE_22
		end
	end

	// Enable state restored from nonvolatile store on the first edge after reset
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			health_en <= 1'b0;
			nv_loaded <= 1'b0;
			nv_write <= 1'b0;
		end
		else
		begin
			nv_loaded <= 1'b1;
			nv_write <= 1'b0;
			if (!nv_loaded)
				health_en <= nv_enable_in; // RULE_10
			else if (wr_cmd && pwdata[7:0] == CMD_HEALTH && lba_hi == KEY_HI
				&& lba_mid == KEY_LO && (feature == FEAT_ENABLE || feature == FEAT_DISABLE))
			begin
				health_en <= feature == FEAT_ENABLE; // RULE_10
				nv_write <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (wr_data)
			sector_buf[word_ptr] <= pwdata[15:0];
		media_buf_data <= sector_buf[media_buf_addr];
	end

	// Task file writes from software; command engine updates the address on progress
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			feature <= 8'h00;
			seccnt <= 8'h01;
			lba_lo <= 8'h01;
			lba_mid <= 8'h00;
			lba_hi <= 8'h00;
			devhead <= 8'ha0;
			spare_thr <= SPARE_THR_RESET;
		end
		else if (access && pwrite && state == S_IDLE)
		begin
			case (paddr)
				OFS_FEATURE: feature <= pwdata[7:0];
				OFS_SECCNT: seccnt <= pwdata[7:0];
				OFS_LBA_LO: lba_lo <= pwdata[7:0];
				OFS_LBA_MID: lba_mid <= pwdata[7:0];
				OFS_LBA_HI: lba_hi <= pwdata[7:0];
				OFS_DEVHEAD: devhead <= pwdata[7:0];
				OFS_SPARE_THR: spare_thr <= pwdata[7:0];
				default: feature <= feature;
			endcase
		end
		else if (state == S_VERIFY && media_vfy_done && media_vfy_ok)
		begin
			// Advance only after a clean verify so a failure keeps its own address
			{devhead[3:0], lba_hi, lba_mid, lba_lo} <= media_lba + 28'h0000001; // RULE_06
			seccnt <= 8'(remaining - 9'h001);
		end
		else if (state == S_ACCEPT && is_write == 1'b0 && feature == FEAT_STATUS)
		begin
			if (spare_value < spare_thr)
			begin
				lba_hi <= KEY_HI_EXCEEDED; // RULE_26
				lba_mid <= KEY_LO_EXCEEDED;
			end
		end
	end

	// Command engine
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= S_IDLE;
			error <= 8'h00;
			err_flag <= 1'b0;
			intrq <= 1'b0;
			remaining <= 9'h000;
			word_ptr <= 8'h00;
			cksum <= 8'h00;
			thr_mode <= 1'b0;
			is_write <= 1'b0;
			media_prog_req <= 1'b0;
			media_vfy_req <= 1'b0;
			snap_commit <= '0;
			snap_wl_thr <= '0;
			snap_avg <= '0;
			snap_blocks <= '0;
			snap_bbm <= 1'b0;
			snap_wl <= 1'b0;
		end
		else
		begin
			if (rd_status)
				intrq <= 1'b0;
			case (state)
				S_IDLE:
				begin
					if (wr_cmd)
					begin
						error <= 8'h00;
						err_flag <= 1'b0;
						word_ptr <= 8'h00;
						cksum <= 8'h00;
						remaining <= seccnt == 8'h00 ? FULL_COUNT : {1'b0, seccnt}; // RULE_04
						is_write <= pwdata[7:0] == CMD_WRITE_VERIFY; // RULE_01
						thr_mode <= feature == FEAT_READ_THR;
						snap_commit <= commit_cnt;
						snap_wl_thr <= wl_thr;
						snap_avg <= avg_erase;
						snap_blocks <= wl_blocks;
						snap_bbm <= global_bbm;
						snap_wl <= global_wl;
						if (pwdata[7:0] == CMD_WRITE_VERIFY)
							state <= S_ACCEPT; // RULE_02
						else if (pwdata[7:0] == CMD_HEALTH && lba_hi == KEY_HI
							&& lba_mid == KEY_LO) // RULE_09
							state <= S_ACCEPT;
						else
						begin
							error[ER_ABRT] <= 1'b1;
							err_flag <= 1'b1;
							intrq <= 1'b1;
						end
					end
				end
				S_ACCEPT:
				begin
					if (is_write)
						state <= S_WR_DRQ; // RULE_05
					else
					begin
						case (feature) // RULE_07
							FEAT_READ_DATA, FEAT_READ_THR:
							begin
								if (health_en)
									state <= S_RD_DRQ; // RULE_12
								else
								begin
									error[ER_ABRT] <= 1'b1;
									err_flag <= 1'b1;
									state <= S_IDLE;
								end
							end
							FEAT_AUTOSAVE:
							begin
								// Health data is always current, so nothing to change
								if (!health_en || (seccnt != AUTOSAVE_OFF && seccnt != AUTOSAVE_ON))
								begin
									error[ER_ABRT] <= 1'b1; // RULE_11
									err_flag <= 1'b1;
								end
								state <= S_IDLE;
							end
							FEAT_ENABLE, FEAT_DISABLE:
								state <= S_IDLE;
							FEAT_STATUS:
							begin
								if (!health_en)
								begin
									error[ER_ABRT] <= 1'b1;
									err_flag <= 1'b1;
								end
								state <= S_IDLE;
							end
							default:
							begin
								error[ER_ABRT] <= 1'b1; // RULE_08
								err_flag <= 1'b1;
								state <= S_IDLE;
							end
						endcase
						intrq <= 1'b1;
					end
				end
				S_WR_DRQ:
				begin
					if (wr_data)
					begin
						word_ptr <= word_ptr + 8'h01;
						if (word_ptr == LAST_WORD_IDX)
						begin
							state <= S_PROG;
							media_prog_req <= 1'b1;
						end
					end
				end
				S_PROG:
				begin
					if (media_prog_done)
					begin
						media_prog_req <= 1'b0;
						media_vfy_req <= 1'b1; // RULE_01
						state <= S_VERIFY;
					end
				end
				S_VERIFY:
				begin
					if (media_vfy_done)
					begin
						media_vfy_req <= 1'b0;
						intrq <= 1'b1; // RULE_05
						if (!media_vfy_ok)
						begin
							error[ER_UNC] <= 1'b1; // RULE_06
							err_flag <= 1'b1;
							state <= S_IDLE;
						end
						else if (remaining == 9'h001)
							state <= S_IDLE;
						else
						begin
							remaining <= remaining - 9'h001;
							state <= S_WR_DRQ;
						end
					end
				end
				S_RD_DRQ:
				begin
					if (rd_data)
					begin
						cksum <= cksum + sector_word[7:0] + sector_word[15:8]; // RULE_18
						word_ptr <= word_ptr + 8'h01;
						if (word_ptr == LAST_WORD_IDX)
							state <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule
